// ===== operating_watchdog_timer.sv
// Operating watchdog with a classic Wishbone register slave.
// Assumes rst_i is the power-on reset and internal_rst_i comes from
// the system reset logic; mode inputs are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module operating_watchdog_timer #(
   parameter logic [7:0] VECTOR_LOW = 8'h00,   // Arbitrary vector byte
   parameter int POR_CYCLES = `WDT_POR_CYCLES
) (
   input wire logic clk_i,                     // Oscillator clock
   input wire logic rst_i,                     // Power-on reset
   input wire logic internal_rst_i,            // Internal reset
   input wire logic wb_cyc_i,                  // Bus cycle
   input wire logic wb_stb_i,                  // Bus strobe
   input wire logic wb_we_i,                   // Write enable
   input wire logic [`WDT_ADDR_W-1:0] wb_adr_i, // Byte address
   input wire logic [31:0] wb_dat_i,           // Write data
   input wire logic [3:0] wb_sel_i,            // Byte selects
   output logic [31:0] wb_dat_o,               // Read data
   output logic wb_ack_o,                      // Acknowledge
   input wire logic stop_exec_i,               // STOP instruction pulse
   input wire logic stop_mode_i,               // In stop mode
   input wire logic wait_mode_i,               // In wait mode
   input wire logic monitor_mode_i,            // Monitor mode
   input wire logic test_high_voltage_i,       // Test voltage on IRQ pin
   input wire logic break_active_i,            // Break interrupt active
   input wire logic break_wdt_disable_i,       // Break disable bit
   output logic wdt_reset_req_o,               // Reset request pulse
   output logic rst_pin_o,                     // Reset pin level
   output logic rst_pin_oe_o,                  // Reset pin drive enable
   output logic stop_ok_o,                     // STOP accepted pulse
   output logic stop_illegal_o,                // STOP illegal pulse
   output logic irq_o                          // Event interrupt
);

   // ------------------------------------------------------------
   // State and prescaler
   // ------------------------------------------------------------
   wdt_pkg::wdt_state_s st_reg;
   wdt_pkg::wdt_state_s st_next;

   logic [`WDT_PRESC_W-1:0] presc;
   logic presc_run;
   logic presc_clr_all;
   logic presc_clr_upper;

   wdt_prescaler #(
      .WIDTH(`WDT_PRESC_W),
      .KEEP(`WDT_PRESC_KEEP)
   ) u_presc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(presc_run),
      .clear_all_i(presc_clr_all),
      .clear_upper_i(presc_clr_upper),
      .count_o(presc)
   );

   // ------------------------------------------------------------
   // Decode and status terms
   // ------------------------------------------------------------
   localparam logic [`WDT_ADDR_W+1:0] SERVICE_WORD =
      {`WDT_SERVICE_INDEX, 2'b00};
   localparam logic [`WDT_ADDR_W-1:0] SERVICE_ADDR =
      SERVICE_WORD[`WDT_ADDR_W-1:0];
   localparam logic [`WDT_POR_CNT_W-1:0] POR_LAST =
      `WDT_POR_CNT_W'(POR_CYCLES - 1);
   localparam logic [`WDT_TOTAL_W-1:0] SHORT_LAST =
      `WDT_TOTAL_W'(`WDT_SHORT_CYCLES - 1);
   localparam logic [`WDT_TOTAL_W-1:0] LONG_LAST =
      `WDT_TOTAL_W'(`WDT_LONG_CYCLES - 1);
   localparam logic [`WDT_PIN_CNT_W-1:0] PIN_LOAD =
      `WDT_PIN_CNT_W'(`WDT_PIN_CYCLES);

   logic take;
   logic wr;
   logic rd;
   logic svc_wr;
   logic svc_rd;
   logic cfg_wr;
   logic active;
   logic expire;
   logic [`WDT_TOTAL_W-1:0] total;
   logic [`WDT_TOTAL_W-1:0] target;
   logic [`WDT_STAT_W-1:0] stat_set;
   logic [`WDT_STAT_W-1:0] stat_clr;

   assign take = wb_cyc_i && wb_stb_i && !st_reg.ack;
   assign wr = take && wb_we_i;
   assign rd = take && !wb_we_i;
   assign svc_wr = wr && (wb_adr_i == SERVICE_ADDR);
   assign svc_rd = rd && (wb_adr_i == SERVICE_ADDR);
   assign cfg_wr = wr && (wb_adr_i == `WDT_OFS_CONFIG) && wb_sel_i[0];

   // Watchdog counts only when enabled, not in stop mode and not held by a debug mode;
   // wait mode has no effect on it.
   assign active = !st_reg.cfg.wdt_disable
      && !(monitor_mode_i && test_high_voltage_i)
      && !(monitor_mode_i && break_active_i && break_wdt_disable_i)
      && !stop_mode_i;

   assign total = {st_reg.cop, presc};
   assign target = st_reg.cfg.wdt_rate_select ? SHORT_LAST
                                              : LONG_LAST;
   assign expire = active && (total == target) && !svc_wr
      && !internal_rst_i;

   // Prescaler control: stop gates the clock, STOP and resets clear it
   assign presc_run = !stop_mode_i;
   assign presc_clr_all = internal_rst_i
      || (stop_exec_i && st_reg.cfg.stop_enable)
      || (st_reg.por == wdt_pkg::POR_WAIT
          && st_reg.por_cnt == POR_LAST);
   assign presc_clr_upper = svc_wr;

   always_comb begin
      stat_set = '0;
      stat_set[`WDT_STAT_CAUSE] = expire;
      stat_set[`WDT_STAT_ILLSTOP] = stop_exec_i
         && !st_reg.cfg.stop_enable;
      stat_set[`WDT_STAT_REFUSED] = cfg_wr && st_reg.cfg_locked;
      stat_clr = '0;
      if (wr && (wb_adr_i == `WDT_OFS_STATUS) && wb_sel_i[0]) begin
         stat_clr = wb_dat_i[`WDT_STAT_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.ack = take;
      st_next.rst_req = expire;
      st_next.stop_ok = stop_exec_i && st_reg.cfg.stop_enable;
      st_next.stop_bad = stop_exec_i && !st_reg.cfg.stop_enable;
      st_next.pin_level = 1'b0;

      // Power-on settle counter
      if (st_reg.por == wdt_pkg::POR_WAIT) begin
         if (st_reg.por_cnt == POR_LAST) begin
            st_next.por = wdt_pkg::POR_DONE;
         end else begin
            st_next.por_cnt = st_reg.por_cnt + 1'b1;
         end
      end

      // Watchdog counter
      if (internal_rst_i || svc_wr) begin
         st_next.cop = '0;
      end else if (active && (&presc)) begin
         st_next.cop = st_reg.cop + 1'b1;
      end

      // Configuration, one write per reset
      if (internal_rst_i) begin
         st_next.cfg = `WDT_CFG_RESET;
         st_next.cfg.reset_pin_enable = st_reg.cfg.reset_pin_enable;
         st_next.cfg_locked = 1'b0;
      end else if (cfg_wr && !st_reg.cfg_locked) begin
         st_next.cfg = wb_dat_i[3:0];
         st_next.cfg_locked = 1'b1;
      end

      // Sticky events, set wins over a clear in the same cycle
      st_next.status = (st_reg.status & ~stat_clr) | stat_set;
      if (wr && (wb_adr_i == `WDT_OFS_MASK) && wb_sel_i[0]) begin
         st_next.mask = wb_dat_i[`WDT_STAT_W-1:0];
      end
      st_next.irq = |(st_next.status & st_next.mask);

      // Reset pin stretch
      if (expire && st_reg.cfg.reset_pin_enable) begin
         st_next.pin_cnt = PIN_LOAD;
      end else if (st_reg.pin_cnt != '0) begin
         st_next.pin_cnt = st_reg.pin_cnt - 1'b1;
      end
      st_next.pin_oe = (st_next.pin_cnt != '0);

      // Register read data
      st_next.dat = '0;
      if (rd) begin
         if (svc_rd) begin
            st_next.dat = {24'h000000, VECTOR_LOW};
         end else if (wb_adr_i == `WDT_OFS_CONFIG) begin
            st_next.dat = {27'h0000000, st_reg.cfg_locked, st_reg.cfg};
         end else if (wb_adr_i == `WDT_OFS_STATUS) begin
            st_next.dat = {29'h00000000, st_reg.status};
         end else if (wb_adr_i == `WDT_OFS_MASK) begin
            st_next.dat = {29'h00000000, st_reg.mask};
         end else if (wb_adr_i == `WDT_OFS_COUNT) begin
            st_next.dat = {14'h0000, total};
         end else begin
            st_next.dat = '0;
         end
      end

      if (rst_i) begin
         st_next = '0;
         st_next.por = wdt_pkg::POR_WAIT;
         st_next.cfg = `WDT_CFG_RESET;
      end
   end

   always_ff @(posedge clk_i) begin
      st_reg <= st_next;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_dat_o = st_reg.dat;
   assign wb_ack_o = st_reg.ack;
   assign wdt_reset_req_o = st_reg.rst_req;
   assign rst_pin_o = st_reg.pin_level;
   assign rst_pin_oe_o = st_reg.pin_oe;
   assign stop_ok_o = st_reg.stop_ok;
   assign stop_illegal_o = st_reg.stop_bad;
   assign irq_o = st_reg.irq;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Length of the current reset pin drive
   logic [7:0] oe_len;
   always_ff @(posedge clk_i) begin
      if (rst_i || !st_reg.pin_oe) begin
         oe_len <= 8'h00;
      end else if (oe_len != 8'hFF) begin
         oe_len <= oe_len + 8'h01;
      end
   end

   sequence s_expire_pin;
      expire ##0 st_reg.cfg.reset_pin_enable;
   endsequence

   sequence s_service;
      svc_wr ##0 !internal_rst_i;
   endsequence

   a_service_clear: assert property (
      s_service |=> (st_reg.cop == '0)
         && (presc[`WDT_PRESC_W-1:`WDT_PRESC_KEEP] == '0))
      else $error("service write did not clear the counters");

   a_vector_read: assert property (
      svc_rd |=> wb_ack_o && (wb_dat_o == {24'h000000, VECTOR_LOW}))
      else $error("service read did not return the vector byte");

   a_pin_stretch: assert property (
      s_expire_pin |=> rst_pin_oe_o [*8] ##1 rst_pin_oe_o)
      else $error("reset pin drive did not start");

   a_pin_length: assert property (
      $fell(rst_pin_oe_o) |-> ($past(oe_len) == 8'(`WDT_PIN_CYCLES - 1)))
      else $error("reset pin drive length wrong");

   a_cause_flag: assert property (
      wdt_reset_req_o |-> st_reg.status[`WDT_STAT_CAUSE])
      else $error("cause flag missing on watchdog reset");

   a_stop_clear: assert property (
      (stop_exec_i && st_reg.cfg.stop_enable) |=> (presc == '0))
      else $error("STOP did not clear the prescaler");

   a_intrst_clear: assert property (
      internal_rst_i |=> (presc == '0) && (st_reg.cop == '0))
      else $error("internal reset left counters set");

   a_disabled_quiet: assert property (
      st_reg.cfg.wdt_disable |=> !wdt_reset_req_o)
      else $error("disabled watchdog requested reset");

   a_monitor_quiet: assert property (
      (monitor_mode_i && test_high_voltage_i) |=> !wdt_reset_req_o)
      else $error("watchdog fired in monitor mode");

   a_break_quiet: assert property (
      (monitor_mode_i && break_active_i && break_wdt_disable_i)
         |=> !wdt_reset_req_o)
      else $error("watchdog fired in break mode");

   a_stop_freeze: assert property (
      (stop_mode_i && !internal_rst_i && !svc_wr) |=> $stable(st_reg.cop))
      else $error("watchdog counted in stop mode");

   a_illegal_stop: assert property (
      (stop_exec_i && !st_reg.cfg.stop_enable)
         |=> stop_illegal_o && !stop_ok_o)
      else $error("illegal STOP not flagged");

   a_cfg_once: assert property (
      (cfg_wr && st_reg.cfg_locked && !internal_rst_i) |=> $stable(st_reg.cfg))
      else $error("locked configuration changed");

   a_wait_counts: assert property (
      (wait_mode_i && active && (&presc) && !svc_wr && !internal_rst_i)
         |=> (st_reg.cop == $past(st_reg.cop) + 6'h01))
      else $error("watchdog stalled in wait mode");

   // Expiry points, worked out apart from the compare logic
   localparam logic [`WDT_TOTAL_W-1:0] CHK_SHORT_END =
      `WDT_TOTAL_W'(`WDT_SHORT_CYCLES - 1);
   localparam logic [`WDT_TOTAL_W-1:0] CHK_LONG_END =
      `WDT_TOTAL_W'(`WDT_LONG_CYCLES - 1);

   sequence s_short_end;
      active && !svc_wr && !internal_rst_i && st_reg.cfg.wdt_rate_select
         && (total == CHK_SHORT_END);
   endsequence

   a_short_expiry: assert property (
      s_short_end |=> wdt_reset_req_o)
      else $error("short timeout missed");

   a_expiry_point: assert property (
      wdt_reset_req_o |-> ($past(total) ==
         ($past(st_reg.cfg.wdt_rate_select) ? CHK_SHORT_END : CHK_LONG_END)))
      else $error("reset request at wrong count");

   a_count_step: assert property (
      (active && !svc_wr && !presc_clr_all)
         |=> (total == $past(total) + 18'h00001))
      else $error("watchdog chain did not advance");

   a_por_clear: assert property (
      (st_reg.por == wdt_pkg::POR_WAIT && st_reg.por_cnt == POR_LAST)
         |=> (presc == '0))
      else $error("power-on settle did not clear prescaler");

   a_req_pulse: assert property (
      wdt_reset_req_o |=> !wdt_reset_req_o)
      else $error("reset request longer than one cycle");

   a_no_wdt_irq: assert property (
      (wdt_reset_req_o && (st_reg.mask == '0)) |-> !irq_o)
      else $error("watchdog expiry raised an interrupt");

   a_cfg_unlock: assert property (
      internal_rst_i |=> !st_reg.cfg_locked)
      else $error("internal reset left configuration locked");

endmodule : operating_watchdog_timer
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the operating watchdog: a table of register
// cases, then stop, timeout, mode-disable and reset tests.
// Assumes the design files and wdt_params.svh are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module tb_top;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   typedef struct packed {
      logic we;
      logic [19:0] adr;
      logic [31:0] wd;
      logic [31:0] exp;
   } row_s;
   localparam logic [19:0] SVC = 20'h3FFFC;
   localparam logic [19:0] UNM = 20'h00100;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic internal_rst_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [19:0] wb_adr_i = 20'h00000;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [3:0] wb_sel_i = 4'h0;
   logic stop_exec_i = 1'b0, stop_mode_i = 1'b0, wait_mode_i = 1'b0;
   logic monitor_mode_i = 1'b0, test_high_voltage_i = 1'b0;
   logic break_active_i = 1'b0, break_wdt_disable_i = 1'b0;
   logic [31:0] wb_dat_o, rd, rd2;
   logic wb_ack_o, wdt_reset_req_o, rst_pin_o, rst_pin_oe_o;
   logic stop_ok_o, stop_illegal_o, irq_o;
   int miscompares = 0, comparisons = 0, n, m;
   row_s rows [16];

   always #5 clk_i = ~clk_i;

   operating_watchdog_timer #(.VECTOR_LOW(8'h5A), .POR_CYCLES(16)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .internal_rst_i(internal_rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .stop_exec_i(stop_exec_i), .stop_mode_i(stop_mode_i),
      .wait_mode_i(wait_mode_i), .monitor_mode_i(monitor_mode_i),
      .test_high_voltage_i(test_high_voltage_i),
      .break_active_i(break_active_i),
      .break_wdt_disable_i(break_wdt_disable_i),
      .wdt_reset_req_o(wdt_reset_req_o), .rst_pin_o(rst_pin_o),
      .rst_pin_oe_o(rst_pin_oe_o), .stop_ok_o(stop_ok_o),
      .stop_illegal_o(stop_illegal_o), .irq_o(irq_o));

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk

   // Classic single cycle; request held until ack is sampled high
   task automatic bus(input logic we, input logic [19:0] adr,
                      input logic [31:0] wd, output logic [31:0] rdat);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      rdat = wb_dat_o;
      chk(32'(k < 50), 32'h1, "bus ack missing");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : bus

   task automatic pulse(input logic to_rst);
      @(posedge clk_i);
      if (to_rst) internal_rst_i <= 1'b1;
      else stop_exec_i <= 1'b1;
      @(posedge clk_i);
      internal_rst_i <= 1'b0;
      stop_exec_i <= 1'b0;
   endtask : pulse

   task automatic wait_req(input int lim, output int cnt);
      cnt = 0;
      while (wdt_reset_req_o !== 1'b1 && cnt < lim) begin
         @(posedge clk_i);
         cnt++;
      end
   endtask : wait_req

   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done

   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   initial begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      final_report();
   end

   // -----------------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------------
   initial begin
      rows = '{
         '{1'b0, 20'h00000, 32'h0, 32'h00000000},
         '{1'b0, 20'h00004, 32'h0, 32'h00000000},
         '{1'b0, 20'h00008, 32'h0, 32'h00000000},
         '{1'b0, SVC, 32'h0, 32'h0000005A},
         '{1'b0, UNM, 32'h0, 32'h00000000},
         '{1'b1, 20'h00000, 32'h0000000E, 32'h0},
         '{1'b0, 20'h00000, 32'h0, 32'h0000001E},
         '{1'b1, 20'h00000, 32'h00000001, 32'h0},
         '{1'b0, 20'h00000, 32'h0, 32'h0000001E},
         '{1'b0, 20'h00004, 32'h0, 32'h00000004},
         '{1'b1, 20'h00008, 32'h00000007, 32'h0},
         '{1'b0, 20'h00008, 32'h0, 32'h00000007},
         '{1'b1, 20'h00004, 32'h00000004, 32'h0},
         '{1'b0, 20'h00004, 32'h0, 32'h00000000},
         '{1'b1, UNM, 32'h000000FF, 32'h0},
         '{1'b0, UNM, 32'h0, 32'h00000000}};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[j]) begin
         bus(rows[j].we, rows[j].adr, rows[j].wd, rd);
         if (!rows[j].we) chk(rd, rows[j].exp, "register table");
      end
      done("table");
      pulse(1'b0);
      @(posedge clk_i);
      chk({31'h0, stop_ok_o}, 32'h1, "stop accepted");
      bus(1'b0, 20'h0000C, 32'h0, rd);
      chk({20'h0, rd[11:4], 4'h0}, 32'h0, "stop clears prescaler");
      @(posedge clk_i);
      stop_mode_i <= 1'b1;
      bus(1'b0, 20'h0000C, 32'h0, rd);
      repeat (20) @(posedge clk_i);
      bus(1'b0, 20'h0000C, 32'h0, rd2);
      chk(rd2, rd, "stop mode freezes count");
      stop_mode_i <= 1'b0;
      done("stop");
      bus(1'b1, SVC, 32'h00000000, rd);
      wait_req(9000, n);
      chk(32'(n >= 8155 && n <= 8180), 32'h1, "short timeout");
      m = 0;
      while (rst_pin_oe_o === 1'b1 && m < 40) begin
         if (rst_pin_o !== 1'b0) chk(32'h1, 32'h0, "pin level");
         m++;
         @(posedge clk_i);
      end
      chk(32'(m), 32'd32, "pin drive length");
      bus(1'b0, 20'h00004, 32'h0, rd);
      chk({31'h0, rd[0]}, 32'h1, "cause flag");
      chk({31'h0, irq_o}, 32'h1, "irq unmasked");
      bus(1'b1, 20'h00008, 32'h0, rd);
      chk({31'h0, irq_o}, 32'h0, "irq masked");
      bus(1'b1, 20'h00004, 32'h7, rd);
      done("expiry");
      pulse(1'b1);
      bus(1'b0, 20'h0000C, 32'h0, rd);
      chk({26'h0, rd[17:12]}, 32'h0, "internal reset clears");
      bus(1'b0, 20'h00000, 32'h0, rd);
      chk(rd, 32'h00000008, "config after internal reset");
      pulse(1'b0);
      @(posedge clk_i);
      chk({31'h0, stop_illegal_o}, 32'h1, "stop illegal");
      bus(1'b0, 20'h00004, 32'h0, rd);
      chk({31'h0, rd[1]}, 32'h1, "illegal stop flag");
      done("illegal stop");
      bus(1'b1, 20'h00000, 32'h2, rd);
      wait_mode_i <= 1'b1;
      bus(1'b1, SVC, 32'hFFFFFFFF, rd);
      wait_req(9000, n);
      chk(32'(n >= 8155 && n <= 8180), 32'h1, "wait mode timeout");
      chk({30'h0, rst_pin_oe_o, irq_o}, 32'h0, "no pin, no irq");
      wait_mode_i <= 1'b0;
      done("wait");
      for (int i = 0; i < 3; i++) begin
         pulse(1'b1);
         bus(1'b1, 20'h00000, (i == 2) ? 32'h3 : 32'h2, rd);
         monitor_mode_i <= (i < 2);
         test_high_voltage_i <= (i == 0);
         break_active_i <= (i == 1);
         break_wdt_disable_i <= (i == 1);
         bus(1'b1, SVC, 32'h0, rd);
         wait_req(8400, n);
         chk(32'(n), 32'd8400, "disabled watchdog fired");
         monitor_mode_i <= 1'b0;
         test_high_voltage_i <= 1'b0;
         break_active_i <= 1'b0;
         break_wdt_disable_i <= 1'b0;
      end
      done("disable");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, 20'h00000, 32'h0, rd);
      chk(rd, 32'h00000000, "config after power-on reset");
      done("reset");
      final_report();
   end
endmodule : tb_top
`default_nettype wire

// ===== wdt_params.svh
// Constants for the operating watchdog: offsets, field positions,
// reset values and timing counts.
// Assumes the watchdog clock is the oscillator output clock, 100 MHz.
//
// Functional notes
// - Watchdog is a 6-bit free-running counter fed by a 12-stage prescaler.
// - Unserviced watchdog requests reset after 8176 or 262128 clock cycles.
// - Any write to the service address clears counter and prescaler 12-5.
// - Reading the service address returns the reset vector low byte.
// - Expiry drives reset pin 32 cycles if enabled and sets cause flag.
// - An executed STOP instruction clears the prescaler.
// - Power-on logic clears the prescaler 4096 cycles after power up.
// - Internal reset clears both the prescaler and the watchdog counter.
// - Disable bit 1 turns the watchdog off; 0 turns it on.
// - Expiry sets the cause flag, which raises an interrupt if its mask bit is set.
// - Watchdog is off in monitor mode with test voltage applied.
// - Watchdog keeps counting during wait mode.
// - Stop mode gates the clock off, so counting halts.
// - Watchdog is off during monitor break when break disable bit set.
// - STOP runs when stop enable is 1, else it is an illegal opcode.
// - Rate bit 1 selects the short timeout, 0 the long one.
// - Configuration accepts one write per reset, readable at any time.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_PRESC_W 12
`define WDT_PRESC_KEEP 4
`define WDT_CNT_W 6
`define WDT_TOTAL_W 18
`define WDT_SHORT_CYCLES 8176
`define WDT_LONG_CYCLES 262128
`define WDT_PIN_CYCLES 32
`define WDT_PIN_CNT_W 6
`define WDT_POR_CYCLES 4096
`define WDT_POR_CNT_W 13

`define WDT_ADDR_W 20
`define WDT_OFS_CONFIG 20'h00000
`define WDT_OFS_STATUS 20'h00004
`define WDT_OFS_MASK 20'h00008
`define WDT_OFS_COUNT 20'h0000C
`define WDT_SERVICE_INDEX 20'h0FFFF

`define WDT_CFG_RESET 4'h0
`define WDT_STAT_W 3
`define WDT_STAT_CAUSE 0
`define WDT_STAT_ILLSTOP 1
`define WDT_STAT_REFUSED 2

`endif

// ===== wdt_pkg.sv
// Types shared by the watchdog modules.
// Assumes wdt_params.svh supplies the widths.
`include "wdt_params.svh"

package wdt_pkg;

   // Configuration bits, bit 0 at the bottom
   typedef struct packed {
      logic reset_pin_enable;
      logic stop_enable;
      logic wdt_rate_select;
      logic wdt_disable;
   } cfg_s;

   typedef enum logic [0:0] {
      POR_WAIT,
      POR_DONE
   } por_e;

   typedef struct packed {
      por_e por;
      logic [`WDT_POR_CNT_W-1:0] por_cnt;
      logic [`WDT_CNT_W-1:0] cop;
      cfg_s cfg;
      logic cfg_locked;
      logic [`WDT_STAT_W-1:0] status;
      logic [`WDT_STAT_W-1:0] mask;
      logic ack;
      logic [31:0] dat;
      logic irq;
      logic rst_req;
      logic pin_oe;
      logic pin_level;
      logic [`WDT_PIN_CNT_W-1:0] pin_cnt;
      logic stop_ok;
      logic stop_bad;
   } wdt_state_s;

endpackage : wdt_pkg

// ===== wdt_prescaler.sv
// Prescaler stage chain ahead of the watchdog counter.
// Assumes clear requests arrive as single-cycle levels from the owner.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module wdt_prescaler #(
   parameter int WIDTH = `WDT_PRESC_W,
   parameter int KEEP = `WDT_PRESC_KEEP
) (
   input wire logic clk_i,                // Oscillator clock
   input wire logic rst_i,                // Synchronous reset
   input wire logic run_i,                // Count enable (clock gate)
   input wire logic clear_all_i,          // Clear every stage
   input wire logic clear_upper_i,        // Clear upper stages only
   output logic [WIDTH-1:0] count_o       // Stage values
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } presc_s;

   presc_s st_reg;
   presc_s st_next;

   always_comb begin
      st_next = st_reg;
      if (rst_i || clear_all_i) begin
         st_next.count = '0;
      end else if (clear_upper_i) begin
         st_next.count = {{(WIDTH-KEEP){1'b0}}, st_reg.count[KEEP-1:0]};
      end else if (run_i) begin
         st_next.count = st_reg.count + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      st_reg <= st_next;
   end

   assign count_o = st_reg.count;

endmodule : wdt_prescaler
`default_nettype wire
